// ### rtl/rbt_pkg.sv
// Shared constants of the registered bus transceiver
`default_nettype none

package rbt_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W  = 18;            // Bits per bus side
  localparam int unsigned REG_AW  = 8;             // Register byte address
  localparam int unsigned REG_DW  = 32;            // Register data width
  localparam int unsigned CTL_W   = 6;             // Control pins sampled
  localparam int unsigned PIN_W   = 2 * DATA_W + CTL_W;
  localparam int unsigned PRIME_W = 2;             // Synchroniser fill time

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;     // Output allow bits
  localparam logic [7:0] OFS_AB_HELD  = 8'h04;     // A-to-B stored word
  localparam logic [7:0] OFS_BA_HELD  = 8'h08;     // B-to-A stored word
  localparam logic [7:0] OFS_PIN_STAT = 8'h0c;     // Sampled control pins

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_AB_ALLOW = 0;       // Let B side be driven
  localparam int unsigned CTRL_BA_ALLOW = 1;       // Let A side be driven
  localparam logic [1:0]  CTRL_RST      = 2'h3;    // Both allowed

  localparam int unsigned ST_OE_AB   = 0;          // Sampled A-to-B enable
  localparam int unsigned ST_OE_BA_N = 1;          // Sampled B-to-A enable_n
  localparam int unsigned ST_LE_AB   = 2;          // Sampled A-to-B latch en
  localparam int unsigned ST_LE_BA   = 3;          // Sampled B-to-A latch en
  localparam int unsigned ST_B_DRV   = 4;          // B side now driven
  localparam int unsigned ST_A_DRV   = 5;          // A side now driven

  // ----------------------------------------------------------------
  // Positions inside the sampled pin vector
  // ----------------------------------------------------------------
  localparam int unsigned PV_A_DATA  = 0;
  localparam int unsigned PV_B_DATA  = DATA_W;
  localparam int unsigned PV_OE_AB   = 2 * DATA_W;
  localparam int unsigned PV_OE_BA_N = 2 * DATA_W + 1;
  localparam int unsigned PV_LE_AB   = 2 * DATA_W + 2;
  localparam int unsigned PV_LE_BA   = 2 * DATA_W + 3;
  localparam int unsigned PV_CK_AB   = 2 * DATA_W + 4;
  localparam int unsigned PV_CK_BA   = 2 * DATA_W + 5;

  localparam logic [DATA_W-1:0] HELD_RST = 18'h00000; // Power-up content

endpackage : rbt_pkg

`default_nettype wire

// ### rtl/rbt_dir_if.sv
// Signals between the top and one direction's storage path
`default_nettype none

interface rbt_dir_if;
  logic [rbt_pkg::DATA_W-1:0] data;     // Sampled source side bus
  logic                       latch_en; // Sampled latch enable
  logic                       clk_lvl;  // Sampled direction clock level
  logic [rbt_pkg::DATA_W-1:0] held;     // Stored word of the direction

  modport path (input data, input latch_en, input clk_lvl, output held);
  modport feed (output data, output latch_en, output clk_lvl, input held);
endinterface : rbt_dir_if

`default_nettype wire

// ### rtl/rbt_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins
`default_nettype none

module rbt_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output var  logic [W-1:0] o_q
);

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  logic [W-1:0] meta_r;  // First stage, read only by the second
  logic [W-1:0] sync_r;  // Second stage, safe for logic

  // Both stages clear on reset; pins are only trusted after two edges
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end

  assign o_q = sync_r;

endmodule : rbt_sync

`default_nettype wire

// ### rtl/rbt_path.sv
// Storage element of one direction: transparent, latch, flip-flop
`default_nettype none

module rbt_path (
  input wire logic i_clk,
  input wire logic i_rst_n,
  rbt_dir_if.path  io
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                       le_prev_r;  // Latch enable one cycle ago
  logic                       ck_prev_r;  // Clock level one cycle ago
  logic [rbt_pkg::PRIME_W-1:0] prime_r;   // Fills while sync settles
  logic [rbt_pkg::DATA_W-1:0] held_r;     // Stored word
  logic                       primed;     // Edges may be trusted
  logic                       le_fall;    // Latch enable went low
  logic                       ck_rise;    // Direction clock went high

  assign primed  = prime_r[rbt_pkg::PRIME_W-1];
  assign le_fall = primed & le_prev_r & ~io.latch_en;
  assign ck_rise = primed & ~ck_prev_r & io.clk_lvl;

  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  // Edges seen while the synchroniser still shows reset zeros are
  // not real, so they stay masked until it has filled
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      le_prev_r <= 1'b0;
      ck_prev_r <= 1'b0;
      prime_r   <= '0;
    end else begin
      le_prev_r <= io.latch_en;
      ck_prev_r <= io.clk_lvl;
      prime_r   <= {prime_r[rbt_pkg::PRIME_W-2:0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Output enable plays no part here, so storage runs alike when
  // the outputs float
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      held_r <= rbt_pkg::HELD_RST;
    end else if (io.latch_en) begin
      held_r <= io.data;                       // Transparent
    end else if (le_fall) begin
      held_r <= io.data;                       // Latch on fall
    end else if (ck_rise) begin
      held_r <= io.data;                       // Clock rising
    end else begin
      held_r <= held_r;                        // Hold
    end
  end

  assign io.held = held_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_TRANSPARENT: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    io.latch_en |=> (io.held == $past(io.data)))
    else $error("Transparent path did not follow its input");

  AST_HOLD: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (!io.latch_en && !le_fall && !ck_rise) |=> $stable(io.held))
    else $error("Stored word changed while holding");

  AST_CLOCK_CAPTURE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (primed && !io.latch_en && !ck_prev_r && io.clk_lvl)
      |=> (io.held == $past(io.data)))
    else $error("Clock rising edge did not capture input");

  AST_FALL_CAPTURE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (primed && le_prev_r && !io.latch_en)
      |=> (io.held == $past(io.data)))
    else $error("Latch enable fall did not capture input");

  AST_NO_FALLING_CLOCK: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (!io.latch_en && !le_prev_r && ck_prev_r && !io.clk_lvl)
      ##1 (!io.latch_en && !io.clk_lvl) |-> $stable(io.held))
    else $error("Falling clock edge changed the stored word");

endmodule : rbt_path

`default_nettype wire

// ### rtl/rbt_top.sv
// Top of the 18-bit registered bus transceiver with register port
//
// The address map and the address-and-strobe port were chosen for this implementation.
`default_nettype none

// Overview of operation
// - Carry 18 bits each way, uninverted, three-state
// - Latch enable high makes storage transparent
// - Latch enable low, clock steady: hold
// - Clock rising edge captures source bus
// - Latch enable falling captures and holds
// - A-to-B enable high drives B side
// - A-to-B enable low floats B side
// - Enables opposite: B-to-A active low
// - B-to-A path mirrors A-to-B independently
// - Clocks act only on rising edge

module rbt_top (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  // A side bus, split into its three signals
  input  wire logic [rbt_pkg::DATA_W-1:0] i_a_side_data,
  output var  logic [rbt_pkg::DATA_W-1:0] o_a_side_data,
  output var  logic [rbt_pkg::DATA_W-1:0] o_a_side_data_oe,
  // B side bus, split into its three signals
  input  wire logic [rbt_pkg::DATA_W-1:0] i_b_side_data,
  output var  logic [rbt_pkg::DATA_W-1:0] o_b_side_data,
  output var  logic [rbt_pkg::DATA_W-1:0] o_b_side_data_oe,
  // Direction controls
  input  wire logic                       i_a_to_b_output_enable,
  input  wire logic                       i_b_to_a_output_enable_n,
  input  wire logic                       i_a_to_b_latch_enable,
  input  wire logic                       i_b_to_a_latch_enable,
  input  wire logic                       i_a_to_b_clock,
  input  wire logic                       i_b_to_a_clock,
  // Register port
  input  wire logic [rbt_pkg::REG_AW-1:0] i_reg_addr,
  input  wire logic [rbt_pkg::REG_DW-1:0] i_reg_wdata,
  input  wire logic                       i_reg_wr,
  input  wire logic                       i_reg_rd,
  output var  logic [rbt_pkg::REG_DW-1:0] o_reg_rdata
);

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic [rbt_pkg::PIN_W-1:0]  pins_raw;  // All asynchronous pins
  logic [rbt_pkg::PIN_W-1:0]  pins_s;    // Same, after two flops
  logic                       oe_ab_s;   // Sampled A-to-B enable
  logic                       oe_ba_n_s; // Sampled B-to-A enable_n

  // Data and controls share one synchroniser so their delays match;
  // a word is only good if the source held it steady across the
  // capture edge, which the driving party guarantees
  assign pins_raw = {i_b_to_a_clock, i_a_to_b_clock,
                     i_b_to_a_latch_enable, i_a_to_b_latch_enable,
                     ~i_b_to_a_output_enable_n, i_a_to_b_output_enable,
                     i_b_side_data, i_a_side_data};

  rbt_sync #(
    .W       (rbt_pkg::PIN_W)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     (pins_raw),
    .o_q     (pins_s)
  );

  assign oe_ab_s   = pins_s[rbt_pkg::PV_OE_AB];
  // The active-low enable crosses inverted, so the synchroniser's reset
  // zeros read as idle and the A side cannot drive while it fills
  assign oe_ba_n_s = ~pins_s[rbt_pkg::PV_OE_BA_N];

  // ----------------------------------------------------------------
  // Direction paths
  // ----------------------------------------------------------------
  rbt_dir_if ab_if ();  // A-to-B storage
  rbt_dir_if ba_if ();  // B-to-A storage, fully separate

  // A-to-B takes the A bus and its own latch enable and clock
  assign ab_if.data     = pins_s[rbt_pkg::PV_A_DATA +: rbt_pkg::DATA_W];
  assign ab_if.latch_en = pins_s[rbt_pkg::PV_LE_AB];
  assign ab_if.clk_lvl  = pins_s[rbt_pkg::PV_CK_AB];

  // B-to-A takes the B bus and its own controls
  assign ba_if.data     = pins_s[rbt_pkg::PV_B_DATA +: rbt_pkg::DATA_W];
  assign ba_if.latch_en = pins_s[rbt_pkg::PV_LE_BA];
  assign ba_if.clk_lvl  = pins_s[rbt_pkg::PV_CK_BA];

  rbt_path u_path_ab (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .io      (ab_if.path)
  );

  rbt_path u_path_ba (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .io      (ba_if.path)
  );

  // Stored words go straight out, uninverted and from flops
  assign o_b_side_data = ab_if.held;
  assign o_a_side_data = ba_if.held;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [1:0] ctrl_r;  // Output allow bits, both set after reset

  // Software can hold a side floating whatever its enable pin says
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_r <= rbt_pkg::CTRL_RST;
    end else if (i_reg_wr && (i_reg_addr == rbt_pkg::OFS_CTRL)) begin
      ctrl_r <= i_reg_wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Output enables
  // ----------------------------------------------------------------
  logic [rbt_pkg::DATA_W-1:0] b_oe_r;  // B side drive, one per bit
  logic [rbt_pkg::DATA_W-1:0] a_oe_r;  // A side drive, one per bit

  // Enables are registered so the drive turns on with its data;
  // after reset both sides float until the pins ask for drive
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      b_oe_r <= '0;
      a_oe_r <= '0;
    end else begin
      // Active high, gated by software allow
      b_oe_r <= {rbt_pkg::DATA_W{oe_ab_s &
                                 ctrl_r[rbt_pkg::CTRL_AB_ALLOW]}};
      // Active low: high pin floats the A side
      a_oe_r <= {rbt_pkg::DATA_W{~oe_ba_n_s &
                                 ctrl_r[rbt_pkg::CTRL_BA_ALLOW]}};
    end
  end

  assign o_b_side_data_oe = b_oe_r;
  assign o_a_side_data_oe = a_oe_r;

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  logic [rbt_pkg::REG_DW-1:0] rdata_r;  // Read answer, one cycle
  logic [rbt_pkg::REG_DW-1:0] rd_mux;   // Selected register word
  logic [5:0]                 pin_stat; // Sampled pin summary

  always_comb begin
    pin_stat                       = '0;
    pin_stat[rbt_pkg::ST_OE_AB]    = oe_ab_s;
    pin_stat[rbt_pkg::ST_OE_BA_N]  = oe_ba_n_s;
    pin_stat[rbt_pkg::ST_LE_AB]    = ab_if.latch_en;
    pin_stat[rbt_pkg::ST_LE_BA]    = ba_if.latch_en;
    pin_stat[rbt_pkg::ST_B_DRV]    = b_oe_r[0];
    pin_stat[rbt_pkg::ST_A_DRV]    = a_oe_r[0];
  end

  // Narrow words sit low; unmapped addresses read as zero
  always_comb begin
    unique case (i_reg_addr)
      rbt_pkg::OFS_CTRL:     rd_mux = {30'h00000000, ctrl_r};
      rbt_pkg::OFS_AB_HELD:  rd_mux = {14'h0000, ab_if.held};
      rbt_pkg::OFS_BA_HELD:  rd_mux = {14'h0000, ba_if.held};
      rbt_pkg::OFS_PIN_STAT: rd_mux = {26'h0000000, pin_stat};
      default:               rd_mux = '0;
    endcase
  end

  // Data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_r <= '0;
    end else if (i_reg_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= '0;
    end
  end

  assign o_reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_AB_PASS: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    ab_if.latch_en |=> (o_b_side_data == $past(ab_if.data)))
    else $error("B side output is not the A input unchanged");

  AST_B_DRIVE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (oe_ab_s && ctrl_r[rbt_pkg::CTRL_AB_ALLOW])
      |=> (o_b_side_data_oe == '1))
    else $error("B side not driven while enabled");

  AST_B_FLOAT: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !oe_ab_s |=> (o_b_side_data_oe == '0))
    else $error("B side driven while its enable is low");

  AST_A_POLARITY: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (oe_ba_n_s |=> (o_a_side_data_oe == '0)) and
    ((!oe_ba_n_s && ctrl_r[rbt_pkg::CTRL_BA_ALLOW])
      |=> (o_a_side_data_oe == '1)))
    else $error("A side drive has the wrong enable polarity");

  AST_BA_PASS: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (ba_if.latch_en && !ab_if.latch_en &&
     $stable(ab_if.latch_en) && $stable(ab_if.clk_lvl))
      |=> (o_a_side_data == $past(ba_if.data)) &&
          $stable(o_b_side_data))
    else $error("B-to-A path not independent of A-to-B");

  AST_OE_INDEPENDENT: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (!oe_ab_s && ab_if.latch_en)
      |=> (ab_if.held == $past(ab_if.data)) && (o_b_side_data_oe == '0))
    else $error("Storage stalled while outputs float");

  AST_RESET: assert property (
    @(posedge i_clk)
    !i_rst_n |=> (o_a_side_data_oe == '0) && (o_b_side_data_oe == '0) &&
                 (ab_if.held == '0) && (ba_if.held == '0))
    else $error("Reset did not clear storage and float outputs");

endmodule : rbt_top

`default_nettype wire

// ### verification/rbt_bus_model.sv
// Model of a bus party on one side of the transceiver
`default_nettype none

module rbt_bus_model (
  input  wire logic                       i_clk,
  input  wire logic [rbt_pkg::DATA_W-1:0] i_dev_data,
  input  wire logic [rbt_pkg::DATA_W-1:0] i_dev_oe,
  input  wire logic [rbt_pkg::DATA_W-1:0] i_drv_data,
  input  wire logic                       i_drv_en,
  output var  logic [rbt_pkg::DATA_W-1:0] o_wire
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  logic [rbt_pkg::DATA_W-1:0] last_r = '0; // Known start, so floats toggle

  // Device wins where it drives; a released wire shows no stale value
  always_comb begin
    for (int i = 0; i < rbt_pkg::DATA_W; i++) begin
      if (i_dev_oe[i]) begin
        o_wire[i] = i_dev_data[i];
      end else if (i_drv_en) begin
        o_wire[i] = i_drv_data[i];     // Held steady by the bench
      end else begin
        o_wire[i] = ~last_r[i];        // Floating: flips every cycle
      end
    end
  end

  // Remember the wire so a floating bit can be inverted
  always_ff @(posedge i_clk) begin
    last_r <= o_wire;
  end
endmodule : rbt_bus_model

`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench of the registered bus transceiver
`default_nettype none

// One comparison; counts it and reports a mismatch at once
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [17:0] ONES = '1;         // Every bit driven
  logic        i_clk = 1'b0;                  // 25 MHz system clock
  logic        i_rst_n = 1'b0;                // Reset, active low
  logic [17:0] a_wire, b_wire;                // Resolved bus levels
  logic [17:0] a_out, a_oe, b_out, b_oe;      // Device drive sides
  logic [17:0] a_drv = '0, b_drv = '0;        // Party data
  logic        a_en = 1'b0, b_en = 1'b0;      // Party drives its bus
  logic        oe_ab = 1'b0, oe_ba_n = 1'b1;  // Output enables idle
  logic        le_ab = 1'b0, le_ba = 1'b0;    // Latch enables
  logic        ck_ab = 1'b0, ck_ba = 1'b0;    // Direction clocks
  logic [7:0]  addr = '0;                     // Register address
  logic [31:0] wdata = '0, rdata, rv;         // Register data
  logic        wr = 1'b0, rd = 1'b0;          // Register strobes
  int          bad_count = 0, cmp_count = 0;  // Verdict counters

  always #20 i_clk = ~i_clk;

  rbt_top i_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_a_side_data(a_wire), .o_a_side_data(a_out),
    .o_a_side_data_oe(a_oe),
    .i_b_side_data(b_wire), .o_b_side_data(b_out),
    .o_b_side_data_oe(b_oe),
    .i_a_to_b_output_enable(oe_ab), .i_b_to_a_output_enable_n(oe_ba_n),
    .i_a_to_b_latch_enable(le_ab), .i_b_to_a_latch_enable(le_ba),
    .i_a_to_b_clock(ck_ab), .i_b_to_a_clock(ck_ba),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata)
  );

  rbt_bus_model i_a_bus (.i_clk(i_clk), .i_dev_data(a_out),
    .i_dev_oe(a_oe), .i_drv_data(a_drv), .i_drv_en(a_en), .o_wire(a_wire));
  rbt_bus_model i_b_bus (.i_clk(i_clk), .i_dev_data(b_out),
    .i_dev_oe(b_oe), .i_drv_data(b_drv), .i_drv_en(b_en), .o_wire(b_wire));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Pins pass two sync flops and one store; four edges leave margin
  task automatic settle;
    repeat (4) @(posedge i_clk);
    #1;
  endtask : settle

  // One-cycle write strobe
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge i_clk) wr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk) begin rd <= 1'b1; addr <= a; end
    @(posedge i_clk) rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Transparent path follows the A bus, bits unchanged
  task automatic t_transparent;
    // Latch enable leads, so storage runs one cycle while B floats
    @(posedge i_clk) le_ab <= 1'b1;
    @(posedge i_clk) begin
      oe_ab <= 1'b1;
      a_drv <= 18'h2a5c3;
      a_en  <= 1'b1;
    end
    settle;
    `CHK(b_out, 18'h2a5c3)
    `CHK(b_oe, ONES)
    @(posedge i_clk) a_drv <= 18'h15a3c;
    settle;
    `CHK(b_out, 18'h15a3c)
    $display("test transparent done");
  endtask : t_transparent

  // Falling latch enable captures; later bus changes are ignored
  task automatic t_latch;
    @(posedge i_clk) a_drv <= 18'h3c0f1;
    settle;                 // Data steady before the capture
    @(posedge i_clk) le_ab <= 1'b0;
    settle;
    @(posedge i_clk) a_drv <= 18'h0ff00;
    settle;
    `CHK(b_out, 18'h3c0f1)
    $display("test latch done");
  endtask : t_latch

  // Rising clock captures, falling clock does nothing
  task automatic t_clock;
    @(posedge i_clk) a_drv <= 18'h21b4d;
    settle;
    @(posedge i_clk) ck_ab <= 1'b1;
    settle;
    `CHK(b_out, 18'h21b4d)
    @(posedge i_clk) a_drv <= 18'h1e1e1;
    settle;
    @(posedge i_clk) ck_ab <= 1'b0;
    settle;
    `CHK(b_out, 18'h21b4d)
    $display("test clock done");
  endtask : t_clock

  // Floating outputs while storage still captures
  task automatic t_float;
    @(posedge i_clk) oe_ab <= 1'b0;
    settle;
    `CHK(b_oe, 18'h00000)
    @(posedge i_clk) a_drv <= 18'h0a0a5;
    settle;
    @(posedge i_clk) ck_ab <= 1'b1;
    settle;
    reg_rd(rbt_pkg::OFS_AB_HELD, rv);
    `CHK(rv, 32'h0000a0a5)
    @(posedge i_clk) begin ck_ab <= 1'b0; oe_ab <= 1'b1; end
    settle;
    `CHK(b_out, 18'h0a0a5)
    $display("test float done");
  endtask : t_float

  // B-to-A path with its active-low enable, independent storage
  task automatic t_back;
    @(posedge i_clk) begin oe_ab <= 1'b0; a_en <= 1'b0; end
    @(posedge i_clk) begin b_drv <= 18'h33cc3; b_en <= 1'b1; end
    @(posedge i_clk) le_ba <= 1'b1;
    settle;
    `CHK(a_oe, 18'h00000)
    @(posedge i_clk) oe_ba_n <= 1'b0;
    settle;
    `CHK(a_oe, ONES)
    `CHK(a_out, 18'h33cc3)
    @(posedge i_clk) le_ba <= 1'b0;
    settle;
    @(posedge i_clk) b_drv <= 18'h0c33c;
    settle;
    @(posedge i_clk) ck_ba <= 1'b1;
    settle;
    `CHK(a_out, 18'h0c33c)
    reg_rd(rbt_pkg::OFS_AB_HELD, rv);
    `CHK(rv, 32'h0000a0a5)
    $display("test back done");
  endtask : t_back

  // Register port: gating, read-only words, unmapped place, status
  task automatic t_regs;
    @(posedge i_clk) begin b_en <= 1'b0; oe_ab <= 1'b1; end
    reg_wr(rbt_pkg::OFS_CTRL, 32'h00000000);
    settle;
    `CHK(b_oe, 18'h00000)
    reg_rd(rbt_pkg::OFS_CTRL, rv);
    `CHK(rv, 32'h00000000)
    reg_wr(rbt_pkg::OFS_CTRL, 32'h00000003);
    reg_wr(rbt_pkg::OFS_AB_HELD, 32'hffffffff);
    reg_rd(8'h10, rv);
    `CHK(rv, 32'h00000000)
    reg_rd(rbt_pkg::OFS_AB_HELD, rv);
    `CHK(rv, 32'h0000a0a5)
    settle;
    reg_rd(rbt_pkg::OFS_PIN_STAT, rv);
    `CHK(rv, 32'h00000031)
    `CHK(b_out, 18'h0a0a5)
    $display("test regs done");
  endtask : t_regs

  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // Whole run is about 140 cycles; this cuts a hang short
  initial begin
    #(40 * 4000);
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge i_clk);
    #1;
    `CHK(a_oe, 18'h00000)
    `CHK(b_oe, 18'h00000)
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    reg_rd(rbt_pkg::OFS_CTRL, rv);
    `CHK(rv, 32'h00000003)
    `CHK(a_oe, 18'h00000)
    reg_rd(rbt_pkg::OFS_AB_HELD, rv);
    `CHK(rv, 32'h00000000)
    settle;                 // Pin edges are ignored just after release
    t_transparent();
    t_latch();
    t_clock();
    t_float();
    t_back();
    t_regs();
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
